// ==== core/dcf_cfg.svh ====
// Purpose: constants for the dual-clock fifo flag block
// Assumes: included by bare name, definitions only
// Notes: byte offsets of the apb registers and their reset values
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH

// register byte offsets
`define DCF_CTRL_OFS 12'h000
`define DCF_LO_OFS_OFS 12'h004
`define DCF_HI_OFS_OFS 12'h008
`define DCF_STAT_OFS 12'h00C

// field positions
`define DCF_CTRL_FALL_BIT 0
`define DCF_STAT_CNT_LSB 16

// reset values
`define DCF_CTRL_RST 1'h0
`define DCF_LO_OFS_RST 16'h0008
`define DCF_HI_OFS_RST 16'h0008

// flag synchroniser depth
`define DCF_SYNC_STAGES 2

`endif

// ==== core/dcf_pkg.sv ====
// Purpose: shared types of the dual-clock fifo flag block
// Assumes: nothing imported, names used as dcf_pkg::name
// Notes: word, offset and apb data types only
package dcf_pkg;

    // one stored fifo word
    typedef logic [35:0] dcf_word_t;

    // almost-empty and almost-full offsets
    typedef logic [15:0] dcf_ofs_t;

    // apb data word
    typedef logic [31:0] dcf_apb_t;

endpackage : dcf_pkg

// ==== core/dcf_fifo.sv ====
// Purpose: fifo with empty/ready, almost-empty, full/ready, almost-full flags
// Assumes: both ports clocked by clk_sys_i, pointers still cross via gray sync
// Notes: offsets and mode set over apb before traffic starts
// Function
// RULE_01: fall-through: output-ready high with new word; low holds word, ignores reads
// RULE_02: standard: empty flag high when memory has word; low holds word, ignores reads
// RULE_03: empty/ready made in read domain; read pointer advances per output load
// RULE_04: fall-through: ready rises and word loads at third read edge after write
// RULE_05: standard: empty flag rises at second read edge after write to empty memory
// RULE_06: write counts for read sync only from an edge at least skew after it
// RULE_07: full/ready high while a location is free; writes ignored while low
// RULE_08: full/ready made in write domain; write pointer advances per accepted word
// RULE_09: full/ready rises at second write edge after read frees a location
// RULE_10: read counts for write sync only from an edge at least skew after it
// RULE_11: almost-empty low at X or fewer words, high at X plus one or more
// RULE_12: almost-empty rises at second read edge after filling write
// RULE_13: almost-empty sync starts only from an edge a second skew after write
// RULE_14: almost-full low at depth minus Y words or more, high below
// RULE_15: almost-full rises at second write edge after reducing read
// RULE_16: almost-full sync starts only from an edge a second skew after read
// RULE_17: output register word not counted; its memory slot is free
// RULE_18: flag thresholds use stored offsets loaded before normal operation
// RULE_19: every flag input crosses through at least two flip-flop stages
// RULE_20: read is chip select low, read direction, enable high, mail low
// RULE_21: pointers cross domains in gray code
//
// The APB register port and the address map are this design's own decisions.
`include "dcf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo #(
    parameter int AW = 8,
    parameter int DW = 36
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // write port
    input wire logic wr_chip_select_n_i,
    input wire logic wr_dir_write_i,
    input wire logic wr_enable_i,
    input wire logic wr_mail_select_i,
    input wire logic [DW-1:0] wr_data_i,
    // read port
    input wire logic read_port_chip_select_n_i,
    input wire logic read_port_dir_read_i,
    input wire logic read_port_enable_i,
    input wire logic read_port_mail_select_i,
    output logic [DW-1:0] rd_data_o,
    // flags
    output logic empty_or_outready_flag_o,
    output logic almost_empty_flag_n_o,
    output logic full_or_inready_flag_o,
    output logic almost_full_flag_n_o
);

    localparam int DEPTH = 1 << AW;
    localparam logic [15:0] DEPTH_W = 16'(DEPTH);

    // gray to binary, used for both synchronised pointers
    function automatic logic [AW:0] g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b = '0;
        for (int i = AW; i >= 0; i--) begin
            b[i] = (i == AW) ? g[i] : (b[i+1] ^ g[i]);
        end
        return b;
    endfunction : g2b

    // binary to gray
    function automatic logic [AW:0] b2g(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : b2g

    // apb address match
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction : hit

    // configuration registers
    logic fall_through_mode_reg;
    dcf_pkg::dcf_ofs_t lo_ofs_reg;
    dcf_pkg::dcf_ofs_t hi_ofs_reg;

    // storage and pointers
    dcf_pkg::dcf_word_t mem_reg [DEPTH];
    logic [AW:0] wbin_reg;
    logic [AW:0] wgray_reg;
    logic [AW:0] rbin_reg;
    logic [AW:0] rgray_reg;
    logic [AW:0] wbin_next;
    logic [AW:0] rbin_next;

    // synchronisers
    logic [AW:0] wg_s1_reg;
    logic [AW:0] wg_s2_reg;
    logic [AW:0] rg_s1_reg;
    logic [AW:0] rg_s2_reg;

    // read side state
    logic or_reg;
    dcf_pkg::dcf_word_t out_reg;
    logic [31:0] prdata_reg;

    // derived terms
    logic wr_req;
    logic wr_acc;
    logic full;
    logic rd_req;
    logic mem_nempty;
    logic load;
    logic [AW:0] rcount;
    logic [AW:0] wcount;

    // port decode
    assign wr_req = !wr_chip_select_n_i && wr_dir_write_i && wr_enable_i && !wr_mail_select_i;
    assign rd_req = !read_port_chip_select_n_i && read_port_dir_read_i
                    && read_port_enable_i && !read_port_mail_select_i; // RULE_20

    // write domain: full compares against synchronised read pointer
    assign full = wgray_reg == {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]}; // RULE_07
    assign wr_acc = wr_req && !full; // RULE_07
    assign wbin_next = wr_acc ? wbin_reg + 1'b1 : wbin_reg; // RULE_08

    // read domain: memory holds a word once the write pointer is seen
    assign mem_nempty = wg_s2_reg != rgray_reg; // RULE_03

    // fall-through loads unrequested when output is stale
    always_comb begin
        if (fall_through_mode_reg) begin
            load = mem_nempty && (!or_reg || rd_req); // RULE_01 RULE_04
        end else begin
            load = mem_nempty && rd_req; // RULE_02 RULE_05
        end
    end

    assign rbin_next = load ? rbin_reg + 1'b1 : rbin_reg; // RULE_03

    // fill levels, output register excluded as its slot is already freed
    assign rcount = g2b(wg_s2_reg) - rbin_reg; // RULE_17
    assign wcount = wbin_reg - g2b(rg_s2_reg); // RULE_17

    // flag outputs
    assign empty_or_outready_flag_o = fall_through_mode_reg ? or_reg : mem_nempty; // RULE_01 RULE_02
    assign full_or_inready_flag_o = !full; // RULE_07 RULE_09
    assign almost_empty_flag_n_o = 16'(rcount) > lo_ofs_reg; // RULE_11 RULE_12 RULE_18
    assign almost_full_flag_n_o = (16'(wcount) + hi_ofs_reg) < DEPTH_W; // RULE_14 RULE_15 RULE_18
    assign rd_data_o = out_reg;

    // memory array, no reset needed for data
    always_ff @(posedge clk_sys_i) begin
        if (wr_acc) begin
            mem_reg[wbin_reg[AW-1:0]] <= wr_data_i;
        end
    end

    // write pointer, binary and gray kept in step
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wbin_reg <= '0;
            wgray_reg <= '0;
        end else begin
            wbin_reg <= wbin_next; // RULE_08
            wgray_reg <= b2g(wbin_next); // RULE_21
        end
    end

    // read pointer
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rbin_reg <= '0;
            rgray_reg <= '0;
        end else begin
            rbin_reg <= rbin_next; // RULE_03
            rgray_reg <= b2g(rbin_next); // RULE_21
        end
    end

    // write pointer into read domain; an edge too close only gets caught next cycle
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wg_s1_reg <= '0;
            wg_s2_reg <= '0;
        end else begin
            wg_s1_reg <= wgray_reg; // RULE_06 RULE_13
            wg_s2_reg <= wg_s1_reg; // RULE_19
        end
    end

    // read pointer into write domain
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rg_s1_reg <= '0;
            rg_s2_reg <= '0;
        end else begin
            rg_s1_reg <= rgray_reg; // RULE_10 RULE_16
            rg_s2_reg <= rg_s1_reg; // RULE_19
        end
    end

    // output register holds the old word unless a load happens
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_reg <= '0;
        end else if (load) begin
            out_reg <= mem_reg[rbin_reg[AW-1:0]]; // RULE_01 RULE_02
        end
    end

    // output-ready state, forced low in standard mode
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            or_reg <= 1'b0;
        end else if (!fall_through_mode_reg) begin
            or_reg <= 1'b0;
        end else if (load) begin
            or_reg <= 1'b1; // RULE_04
        end else if (rd_req) begin
            or_reg <= 1'b0; // RULE_01
        end
    end

    // apb writes take effect at the access edge
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fall_through_mode_reg <= `DCF_CTRL_RST;
            lo_ofs_reg <= `DCF_LO_OFS_RST;
            hi_ofs_reg <= `DCF_HI_OFS_RST;
        end else if (psel_i && penable_i && pwrite_i) begin
            if (hit(paddr_i, `DCF_CTRL_OFS)) begin
                fall_through_mode_reg <= pwdata_i[`DCF_CTRL_FALL_BIT];
            end
            if (hit(paddr_i, `DCF_LO_OFS_OFS)) begin
                lo_ofs_reg <= pwdata_i[15:0]; // RULE_18
            end
            if (hit(paddr_i, `DCF_HI_OFS_OFS)) begin
                hi_ofs_reg <= pwdata_i[15:0]; // RULE_18
            end
        end
    end

    // read data captured in setup so the access phase needs no wait state
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_reg <= '0;
        end else if (psel_i && !penable_i) begin
            case (paddr_i)
                `DCF_CTRL_OFS: begin
                    prdata_reg <= {31'h0, fall_through_mode_reg};
                end
                `DCF_LO_OFS_OFS: begin
                    prdata_reg <= {16'h0, lo_ofs_reg};
                end
                `DCF_HI_OFS_OFS: begin
                    prdata_reg <= {16'h0, hi_ofs_reg};
                end
                `DCF_STAT_OFS: begin
                    prdata_reg <= {16'(rcount), 12'h000, empty_or_outready_flag_o,
                                   almost_empty_flag_n_o, full_or_inready_flag_o,
                                   almost_full_flag_n_o};
                end
                default: begin
                    prdata_reg <= '0;
                end
            endcase
        end
    end

    // apb answer: always ready, error for unmapped address
    assign prdata_o = prdata_reg;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !(hit(paddr_i, `DCF_CTRL_OFS)
                       || hit(paddr_i, `DCF_LO_OFS_OFS) || hit(paddr_i, `DCF_HI_OFS_OFS)
                       || hit(paddr_i, `DCF_STAT_OFS));

    // checks share one clock and reset
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    // fifo truly empty in both views; first sync stage left alone, only the second is read
    logic all_empty;
    assign all_empty = (wgray_reg == rgray_reg) && (wg_s2_reg == rgray_reg);

    a_wr_full_ignored: assert property ( // RULE_07
        wr_req && !full_or_inready_flag_o |=> $stable(wbin_reg))
        else $error("write accepted while full");

    a_wptr_advance: assert property ( // RULE_08
        wr_acc |=> wbin_reg == $past(wbin_reg) + 1'b1)
        else $error("write pointer did not advance");

    a_rptr_on_load: assert property ( // RULE_03
        $changed(out_reg) |-> rbin_reg == $past(rbin_reg) + 1'b1)
        else $error("output load without pointer advance");

    a_std_empty_hold: assert property ( // RULE_02
        !fall_through_mode_reg && !empty_or_outready_flag_o && rd_req
        |=> $stable(out_reg) && $stable(rbin_reg))
        else $error("read taken while empty");

    a_fall_out_hold: assert property ( // RULE_01
        fall_through_mode_reg && !or_reg && !mem_nempty |=> $stable(out_reg))
        else $error("output changed while not ready");

    a_fall_latency: assert property ( // RULE_04
        fall_through_mode_reg && all_empty && !or_reg && wr_acc
        && !(psel_i && pwrite_i)
        |=> !or_reg ##1 !or_reg ##1 !or_reg ##1 or_reg)
        else $error("output-ready not raised at third edge");

    a_std_latency: assert property ( // RULE_05
        !fall_through_mode_reg && all_empty && wr_acc && !(psel_i && pwrite_i)
        |=> !empty_or_outready_flag_o ##1 !empty_or_outready_flag_o
            ##1 empty_or_outready_flag_o)
        else $error("empty flag not raised at second edge");

    a_full_release: assert property ( // RULE_09
        full && load |=> full ##1 full ##1 !full)
        else $error("full/ready not raised at second edge");

    a_lo_level: assert property ( // RULE_11
        $rose(almost_empty_flag_n_o) |-> 16'(rcount) >= lo_ofs_reg + 16'h0001)
        else $error("almost-empty high at low fill");

    a_hi_level: assert property ( // RULE_14
        !almost_full_flag_n_o |-> 16'(wcount) >= DEPTH_W - hi_ofs_reg)
        else $error("almost-full low below threshold");

endmodule : dcf_fifo

`default_nettype wire

// ==== verif/dcf_host.sv ====
// Purpose: host model driving the fifo write and read ports
// Assumes: bench requests change just after a rising edge
// Notes: idle write data shows the inverse of the last word, never a stale copy
`timescale 1ns/1ps
`default_nettype none

module dcf_host (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // bench requests
    input wire logic wr_req_i,
    input wire logic [35:0] wr_word_i,
    input wire logic rd_req_i,
    input wire logic rd_mail_i,
    // write port
    output logic wr_cs_n_o,
    output logic wr_dir_o,
    output logic wr_en_o,
    output logic wr_mail_o,
    output logic [35:0] wr_data_o,
    // read port
    output logic read_port_chip_select_n_o,
    output logic rd_dir_o,
    output logic read_port_enable_o,
    output logic read_port_mail_select_o
);
    logic [35:0] last_reg;

    // last word written, used to scramble idle data
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            last_reg <= 36'h0;
        end else if (wr_req_i) begin
            last_reg <= wr_word_i;
        end
    end

    // write strobes, mailbox never used
    assign wr_cs_n_o = !wr_req_i;
    assign wr_dir_o = 1'h1;
    assign wr_en_o = wr_req_i;
    assign wr_mail_o = 1'h0;
    assign wr_data_o = wr_req_i ? wr_word_i : ~last_reg;
    // read request: select low, read, enable high, mail as asked
    assign read_port_chip_select_n_o = !rd_req_i;
    assign rd_dir_o = rd_req_i;
    assign read_port_enable_o = rd_req_i;
    assign read_port_mail_select_o = rd_mail_i;
endmodule : dcf_host
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench for the fifo flag block
// Assumes: depth cut to 16 words, zero-wait apb
// Notes: flags sampled at the rising edge, so a latency of two edges reads as three
`timescale 1ns/1ps
`default_nettype none
`include "dcf_cfg.svh"

module tb_top;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    dcf_pkg::dcf_apb_t pwdata, prdata, rdv;
    logic wr_req, rd_req, rd_mail, w_cs_n, w_dir, w_en, w_mail, r_cs_n, r_dir, r_en, r_mail;
    dcf_pkg::dcf_word_t wr_word, w_data, rd_data;
    logic f_e, f_lo, f_f, f_hi;
    int fails = 0;
    int compares = 0;
    int n, i;

    // clock generator
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    dcf_fifo #(.AW(4), .DW(36)) uut (.clk_sys_i(clk), .rst_b_i(rst_b), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .wr_chip_select_n_i(w_cs_n), .wr_dir_write_i(w_dir), .wr_enable_i(w_en),
        .wr_mail_select_i(w_mail), .wr_data_i(w_data), .read_port_chip_select_n_i(r_cs_n),
        .read_port_dir_read_i(r_dir), .read_port_enable_i(r_en),
        .read_port_mail_select_i(r_mail), .rd_data_o(rd_data),
        .empty_or_outready_flag_o(f_e), .almost_empty_flag_n_o(f_lo),
        .full_or_inready_flag_o(f_f), .almost_full_flag_n_o(f_hi));

    dcf_host host (.clk_sys_i(clk), .rst_b_i(rst_b), .wr_req_i(wr_req), .wr_word_i(wr_word),
        .rd_req_i(rd_req), .rd_mail_i(rd_mail), .wr_cs_n_o(w_cs_n), .wr_dir_o(w_dir),
        .wr_en_o(w_en), .wr_mail_o(w_mail), .wr_data_o(w_data),
        .read_port_chip_select_n_o(r_cs_n), .rd_dir_o(r_dir),
        .read_port_enable_o(r_en), .read_port_mail_select_o(r_mail));

    function automatic dcf_pkg::dcf_word_t fl();
        return {32'h0, f_e, f_lo, f_f, f_hi};
    endfunction : fl

    task give_verdict();
        $display("counts: compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    task chk(input dcf_pkg::dcf_word_t got, input dcf_pkg::dcf_word_t exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task chk_reg(input dcf_pkg::dcf_apb_t got, input dcf_pkg::dcf_apb_t exp);
        chk({4'h0, got}, {4'h0, exp});
    endtask : chk_reg

    // one apb transfer, then an idle edge so psel is never reassigned at once
    task apb(input logic wr, input logic [11:0] a, input dcf_pkg::dcf_apb_t wd);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'h1) break;
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
        if (i == 16) begin
            fails++;
            give_verdict();
        end
    endtask : apb

    // edges until flag bit s is seen high
    task wait_flag(input int s, output int cnt);
        for (cnt = 1; cnt <= 40; cnt++) begin
            @(posedge clk);
            if (((fl() >> s) & 36'h1) === 36'h1) break;
        end
        if (cnt > 40) begin
            fails++;
            give_verdict();
        end
    endtask : wait_flag

    task put(input dcf_pkg::dcf_word_t w);
        wr_req <= 1'h1;
        wr_word <= w;
        @(posedge clk);
    endtask : put

    task get(input logic m);
        rd_req <= 1'h1;
        rd_mail <= m;
        @(posedge clk);
    endtask : get

    // main sequence
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        wr_req = 1'h0;
        wr_word = 36'h0;
        rd_req = 1'h0;
        rd_mail = 1'h0;
        rst_b = 1'h0;
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        chk(fl(), 36'h3);
        chk(rd_data, 36'h0);
        apb(1'h0, `DCF_STAT_OFS, 32'h0);
        chk_reg(rdv, 32'h3);
        apb(1'h0, `DCF_LO_OFS_OFS, 32'h0);
        chk_reg(rdv, 32'h8);
        apb(1'h0, 12'h010, 32'h0);
        chk_reg({31'h0, err}, 32'h1);
        chk_reg(rdv, 32'h0);
        apb(1'h1, `DCF_LO_OFS_OFS, 32'h2);
        apb(1'h1, `DCF_HI_OFS_OFS, 32'h4);
        apb(1'h0, `DCF_HI_OFS_OFS, 32'h0);
        chk_reg(rdv, 32'h4);
        $display("test reset done");
        get(1'h0);
        rd_req <= 1'h0;
        @(posedge clk);
        chk(rd_data, 36'h0);
        put(36'hA5A5A5A5A);
        wr_req <= 1'h0;
        wait_flag(3, n);
        chk(36'(n), 36'h3);
        get(1'h1);
        rd_req <= 1'h0;
        rd_mail <= 1'h0;
        @(posedge clk);
        chk(rd_data, 36'h0);
        get(1'h0);
        rd_req <= 1'h0;
        @(posedge clk);
        chk(rd_data, 36'hA5A5A5A5A);
        $display("test standard done");
        // two writes beyond depth must be dropped
        for (int k = 0; k < 18; k++) put(36'h100 + 36'(k));
        wr_req <= 1'h0;
        repeat (4) @(posedge clk);
        chk(fl(), 36'hC);
        apb(1'h0, `DCF_STAT_OFS, 32'h0);
        chk_reg(rdv, 32'h0010000C);
        get(1'h0);
        rd_req <= 1'h0;
        wait_flag(1, n);
        chk(36'(n), 36'h3);
        chk(rd_data, 36'h100);
        rd_req <= 1'h1;
        @(posedge clk);
        for (int k = 2; k < 16; k++) begin
            @(posedge clk);
            chk(rd_data, 36'h100 + 36'(k - 1));
        end
        rd_req <= 1'h0;
        @(posedge clk);
        chk(rd_data, 36'h10F);
        repeat (4) @(posedge clk);
        get(1'h0);
        rd_req <= 1'h0;
        @(posedge clk);
        chk(rd_data, 36'h10F);
        chk(fl(), 36'h3);
        $display("test fill done");
        apb(1'h1, `DCF_CTRL_OFS, 32'h1);
        put(36'h123456789);
        wr_req <= 1'h0;
        wait_flag(3, n);
        chk(36'(n), 36'h4);
        chk(rd_data, 36'h123456789);
        apb(1'h0, `DCF_STAT_OFS, 32'h0);
        chk_reg(rdv, 32'hB);
        get(1'h0);
        rd_req <= 1'h0;
        @(posedge clk);
        chk(fl(), 36'h3);
        $display("test fall-through done");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
